// ==== wdm_watchdog_ctrl.sv ====
`timescale 1ns/10ps
`include "wdm_consts.svh"
// Behaviour
// - time-out in interrupt mode sets flag
// - vector or written one clears flag
// - interrupt needs flag, enable, global enable
// - irq enable only: interrupt on time-out
// - combined mode: first time-out sets flag
// - combined vector clears enable and flag
// - combined unserviced second time-out resets system
// - programmed fuse forces system reset mode
// - reset-enable clear, prescale change need window
// - change window closes after four cycles
// - taken interrupt clears global enable; return sets
// - global enable clear blocks every interrupt
// - low registers also at offset minus 0x20
module wdm_watchdog_ctrl
  import wdm_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // core i/o bus
  input wire logic [7:0] busAddr,
  input wire logic busIoSpace,
  input wire logic busWrEn,
  input wire logic busRdEn,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  // core events
  input wire logic irqAck,
  input wire logic wdVecAck,
  input wire logic retInstr,
  input wire logic setGlobalIrq,
  input wire logic clearGlobalIrq,
  input wire logic wdKick,
  // fuse pin
  input wire logic forcedResetFuse,
  // requests and global enable
  output logic irqReq,
  output logic sysResetReq,
  output logic globalIrqEn
);

  // fuse synchroniser
  logic fuseMeta_r;
  logic fuseSync_r;

  // register state
  logic tmoFlag_r;
  logic tmoFlag_nxt;
  logic irqEn_r;
  logic irqEn_nxt;
  logic rstEn_r;
  logic rstEn_nxt;
  logic [3:0] presSel_r;
  logic [3:0] presSel_nxt;
  logic globalIe_r;
  logic globalIe_nxt;
  logic irqReq_r;
  logic sysResetReq_r;
  logic [7:0] busRdData_r;
  logic [7:0] busRdData_nxt;

  wdm_mode_t mode;
  logic chgActive;

  wdm_tmo_if tmo ();

  // address decode
  wire [7:0] effAddr;
  wire ioInRange;
  wire selCtrl;
  wire selCore;
  wire ctrlWr;
  wire coreWr;

  assign effAddr = busIoSpace ? 8'(busAddr + `WDM_IO_OFFSET) : busAddr;
  assign ioInRange = !busIoSpace || (busAddr <= `WDM_IO_MAX);
  assign selCtrl = ioInRange && (effAddr == `WDM_OFS_CTRL);
  assign selCore = ioInRange && (effAddr == `WDM_OFS_CORE_STATUS);
  assign ctrlWr = busWrEn && selCtrl;
  assign coreWr = busWrEn && selCore;

  // mode selection
  wire fuseProgrammed;
  assign fuseProgrammed = !fuseSync_r;

  always_comb begin
    if (fuseProgrammed) begin
      mode = WDM_RESET;
    end else begin
      unique case ({rstEn_r, irqEn_r})
        2'b00: mode = WDM_STOPPED;
        2'b01: mode = WDM_IRQ;
        2'b10: mode = WDM_RESET;
        2'b11: mode = WDM_IRQ_RESET;
      endcase
    end
  end

  // time-out actions
  wire tmoSetFlag;
  wire tmoReset;
  wire combined;

  assign combined = (mode == WDM_IRQ_RESET);
  assign tmoSetFlag = tmo.expire && ((mode == WDM_IRQ) || (combined && !tmoFlag_r));
  assign tmoReset = tmo.expire && ((mode == WDM_RESET) || (combined && tmoFlag_r));

  assign tmo.run = (mode != WDM_STOPPED);
  // the wrap at the limit already restarts; a second restart would stretch the period
  assign tmo.restart = wdKick;
  assign tmo.presSel = presSel_r;

  // change window
  wire chgOpen;
  assign chgOpen = ctrlWr && busWrData[`WDM_BIT_CHG_WIN];

  wdm_change_window u_chgWin (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .open(chgOpen),
    .active(chgActive)
  );

  wdm_timeout_counter u_tmoCnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .tmo(tmo.cnt)
  );

  // flag: a time-out in the same cycle as a clear wins
  always_comb begin
    tmoFlag_nxt = tmoFlag_r;
    if (wdVecAck || (ctrlWr && busWrData[`WDM_BIT_FLAG])) begin
      tmoFlag_nxt = 1'b0;
    end
    if (tmoSetFlag) begin
      tmoFlag_nxt = 1'b1;
    end
  end

  // enables and prescaler
  always_comb begin
    irqEn_nxt = irqEn_r;
    rstEn_nxt = rstEn_r;
    presSel_nxt = presSel_r;
    if (ctrlWr) begin
      irqEn_nxt = busWrData[`WDM_BIT_IRQ_EN];
      if (busWrData[`WDM_BIT_RST_EN]) begin
        rstEn_nxt = 1'b1;
      end else if (chgActive) begin
        rstEn_nxt = 1'b0;
      end
      if (chgActive) begin
        presSel_nxt = {busWrData[`WDM_BIT_PRES_MSB], busWrData[`WDM_BIT_PRES_B2],
                       busWrData[`WDM_BIT_PRES_B1], busWrData[`WDM_BIT_PRES_LSB]};
      end
    end
    // servicing the combined mode drops back to reset mode
    if (wdVecAck && combined) begin
      irqEn_nxt = 1'b0;
    end
  end

  // global interrupt enable; a taken interrupt has the last word
  always_comb begin
    globalIe_nxt = globalIe_r;
    if (coreWr) begin
      globalIe_nxt = busWrData[`WDM_BIT_GLOBAL_IE];
    end
    if (retInstr || setGlobalIrq) begin
      globalIe_nxt = 1'b1;
    end
    if (clearGlobalIrq || irqAck) begin
      globalIe_nxt = 1'b0;
    end
  end

  // read data; other core status bits live in the core
  wire [7:0] ctrlView;
  assign ctrlView = {tmoFlag_r, irqEn_r, presSel_r[3], chgActive, rstEn_r, presSel_r[2:0]};

  always_comb begin
    busRdData_nxt = 8'h00;
    if (busRdEn && selCtrl) begin
      busRdData_nxt = ctrlView;
    end else if (busRdEn && selCore) begin
      busRdData_nxt = {globalIe_r, 7'h00};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fuseMeta_r <= 1'b1;
      fuseSync_r <= 1'b1;
    end else if (clkEn) begin
      fuseMeta_r <= forcedResetFuse;
      fuseSync_r <= fuseMeta_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tmoFlag_r <= 1'(`WDM_RST_CTRL >> `WDM_BIT_FLAG);
      irqEn_r <= 1'b0;
      rstEn_r <= 1'b0;
      presSel_r <= 4'h0;
    end else if (clkEn) begin
      tmoFlag_r <= tmoFlag_nxt;
      irqEn_r <= irqEn_nxt;
      rstEn_r <= rstEn_nxt;
      presSel_r <= presSel_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      globalIe_r <= 1'b0;
      irqReq_r <= 1'b0;
      sysResetReq_r <= 1'b0;
      busRdData_r <= 8'h00;
    end else if (clkEn) begin
      globalIe_r <= globalIe_nxt;
      irqReq_r <= tmoFlag_r && irqEn_r && globalIe_r;
      sysResetReq_r <= tmoReset;
      busRdData_r <= busRdData_nxt;
    end
  end

  assign irqReq = irqReq_r;
  assign sysResetReq = sysResetReq_r;
  assign globalIrqEn = globalIe_r;
  assign busRdData = busRdData_r;

endmodule // wdm_watchdog_ctrl

// ==== wdm_consts.svh ====
`ifndef WDM_CONSTS_SVH
`define WDM_CONSTS_SVH

// data-space offsets
`define WDM_OFS_CTRL 8'h60
`define WDM_OFS_CORE_STATUS 8'h5f
// port-instruction space sits this far below data space
`define WDM_IO_OFFSET 8'h20
`define WDM_IO_MAX 8'h3f

// control/status field positions
`define WDM_BIT_FLAG 7
`define WDM_BIT_IRQ_EN 6
`define WDM_BIT_PRES_MSB 5
`define WDM_BIT_CHG_WIN 4
`define WDM_BIT_RST_EN 3
`define WDM_BIT_PRES_B2 2
`define WDM_BIT_PRES_B1 1
`define WDM_BIT_PRES_LSB 0
`define WDM_BIT_GLOBAL_IE 7

// reset values
`define WDM_RST_CTRL 8'h00
`define WDM_RST_CORE_STATUS 8'h00

// timing counts
`define WDM_CHG_WIN_CYCLES 3'h4
`define WDM_TMO_BASE_CYCLES 13'h0008
`define WDM_TMO_MAX_SEL 4'h9

`endif

// ==== wdm_pkg.sv ====
package wdm_pkg;

  typedef enum logic [1:0] {
    WDM_STOPPED,
    WDM_IRQ,
    WDM_RESET,
    WDM_IRQ_RESET
  } wdm_mode_t;

endpackage

// ==== wdm_tmo_if.sv ====
`timescale 1ns/10ps
interface wdm_tmo_if;
  logic run;
  logic restart;
  logic [3:0] presSel;
  logic expire;

  modport ctl (
    output run,
    output restart,
    output presSel,
    input expire
  );

  modport cnt (
    input run,
    input restart,
    input presSel,
    output expire
  );
endinterface // wdm_tmo_if

// ==== wdm_timeout_counter.sv ====
`timescale 1ns/10ps
`include "wdm_consts.svh"
module wdm_timeout_counter
  import wdm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // control side
  wdm_tmo_if.cnt tmo
);

  logic [12:0] cnt_r;
  logic expire_r;
  wire [3:0] selClamp;
  wire [12:0] limit;
  wire atLimit;

  // selections past the longest period saturate there
  assign selClamp = (tmo.presSel > `WDM_TMO_MAX_SEL) ? `WDM_TMO_MAX_SEL : tmo.presSel;
  assign limit = 13'((`WDM_TMO_BASE_CYCLES << selClamp) - 13'h0001);
  assign atLimit = (cnt_r == limit);
  assign tmo.expire = expire_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= 13'h0000;
      expire_r <= 1'b0;
    end else if (clkEn) begin
      expire_r <= tmo.run && !tmo.restart && atLimit;
      if (!tmo.run || tmo.restart || atLimit) begin
        cnt_r <= 13'h0000;
      end else begin
        cnt_r <= cnt_r + 13'h0001;
      end
    end
  end

endmodule // wdm_timeout_counter

// ==== wdm_change_window.sv ====
`timescale 1ns/10ps
`include "wdm_consts.svh"
module wdm_change_window
  import wdm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // window control
  input wire logic open,
  output logic active
);

  logic [2:0] cnt_r;

  assign active = (cnt_r != 3'h0);

  // a fresh write restarts the full window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= 3'h0;
    end else if (clkEn) begin
      if (open) begin
        cnt_r <= `WDM_CHG_WIN_CYCLES;
      end else if (active) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

endmodule // wdm_change_window

// ==== wdm_watchdog_ctrl_assertions.sv ====
`timescale 1ns/10ps
module wdm_watchdog_ctrl_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // bus
  input wire logic [7:0] busAddr,
  input wire logic busIoSpace,
  input wire logic busWrEn,
  input wire logic busRdEn,
  input wire logic [7:0] busWrData,
  input wire logic [7:0] busRdData,
  // events, requests, global enable
  input wire logic irqAck,
  input wire logic retInstr,
  input wire logic setGlobalIrq,
  input wire logic clearGlobalIrq,
  input wire logic irqReq,
  input wire logic sysResetReq,
  input wire logic globalIrqEn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire stHit = busIoSpace ? busAddr == 8'h3f : busAddr == 8'h5f;
  wire evt = irqAck | retInstr | setGlobalIrq | clearGlobalIrq;
  sequence sTaken;
    clkEn && irqAck ##1 clkEn;
  endsequence
  chk_gate_blocks: assert property (clkEn && !globalIrqEn |=> !irqReq)
    else $error("irq while blocked");
  chk_taken_clears: assert property (sTaken |-> !globalIrqEn ##1 !irqReq)
    else $error("taken irq kept enable");
  chk_ret_sets: assert property (clkEn && retInstr && !irqAck && !clearGlobalIrq |=> globalIrqEn)
    else $error("return left enable clear");
  chk_clear_wins: assert property (clkEn && clearGlobalIrq |=> !globalIrqEn)
    else $error("clear ignored");
  chk_reset_pulse: assert property (clkEn && sysResetReq |=> !sysResetReq)
    else $error("reset request too long");
  chk_read_idle: assert property (clkEn && !busRdEn |=> busRdData == 8'h00)
    else $error("read data without read");
  chk_status_read: assert property (clkEn && busRdEn && stHit |=> busRdData == {$past(globalIrqEn), 7'h00})
    else $error("status read wrong");
  chk_status_write: assert property (clkEn && busWrEn && stHit && !evt |=> globalIrqEn == $past(busWrData[7]))
    else $error("status write lost");
endmodule // wdm_watchdog_ctrl_chk

bind wdm_watchdog_ctrl wdm_watchdog_ctrl_chk wdm_watchdog_ctrl_chk_i (.ref_clk, .rst, .clkEn, .busAddr,
  .busIoSpace, .busWrEn, .busRdEn, .busWrData, .busRdData, .irqAck, .retInstr, .setGlobalIrq,
  .clearGlobalIrq, .irqReq, .sysResetReq, .globalIrqEn);

// ==== wdm_watchdog_ctrl_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module wdm_watchdog_ctrl_tb_top;
  logic ref_clk = 1'h0, rst = 1'h1, clkEn = 1'h1, busIoSpace = 1'h0, busWrEn = 1'h0, busRdEn = 1'h0;
  logic irqAck = 1'h0, wdVecAck = 1'h0, retInstr = 1'h0, setGlobalIrq = 1'h0, clearGlobalIrq = 1'h0;
  logic wdKick = 1'h0, forcedResetFuse = 1'h1, irqReq, sysResetReq, globalIrqEn;
  logic [7:0] busAddr = 8'h00, busWrData = 8'h00, busRdData;
  int n_errors = 0, cmp_count = 0, seed = 16284, nRst = 0, k, m;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sysResetReq === 1'h1) nRst++;
  wdm_watchdog_ctrl wdm_watchdog_ctrl_i (.ref_clk, .rst, .clkEn, .busAddr, .busIoSpace, .busWrEn, .busRdEn,
    .busWrData, .busRdData, .irqAck, .wdVecAck, .retInstr, .setGlobalIrq, .clearGlobalIrq, .wdKick,
    .forcedResetFuse, .irqReq, .sysResetReq, .globalIrqEn);
  task automatic cyc(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic doReset(logic f);
    forcedResetFuse <= f;
    rst <= 1'h1;
    cyc(5);
    rst <= 1'h0;
  endtask
  // more keeps the strobe up for a back-to-back write
  task automatic wr(logic [7:0] a, logic [7:0] d, logic io = 1'h0, bit more = 0);
    busAddr <= a;
    busIoSpace <= io;
    busWrData <= d;
    busWrEn <= 1'h1;
    cyc();
    if (!more) busWrEn <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a, logic io, logic [7:0] e);
    busAddr <= a;
    busIoSpace <= io;
    busRdEn <= 1'h1;
    cyc();
    busRdEn <= 1'h0;
    cyc();
    `CHK("busRdData", e, busRdData)
  endtask
  // bits: ack, vector, return, set, clear, kick
  task automatic ev(logic [5:0] w);
    {irqAck, wdVecAck, retInstr, setGlobalIrq, clearGlobalIrq, wdKick} <= w;
    cyc();
    {irqAck, wdVecAck, retInstr, setGlobalIrq, clearGlobalIrq, wdKick} <= 6'h00;
  endtask
  task automatic waitHi(bit s, int n);
    for (k = 0; k < n && (s ? sysResetReq : irqReq) !== 1'h1; k++) cyc();
    `CHK(s ? "sysResetReq" : "irqReq", 1'h1, s ? sysResetReq : irqReq)
    if (k == n) summarize();
  endtask
  initial begin
    cyc();
    doReset(1'h1);
    rd(8'h60, 1'h0, 8'h00);
    rd(8'h3f, 1'h1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(8'h80 | 8'($random(seed)), 1'h0, 8'h00);
      rd(8'h3e & 8'($random(seed)), 1'h1, 8'h00);
    end
    wr(8'h3f, 8'h80, 1'h1);
    rd(8'h5f, 1'h0, 8'h80);
    ev(6'h20);
    rd(8'h5f, 1'h0, 8'h00);
    ev(6'h08);
    rd(8'h3f, 1'h1, 8'h80);
    wr(8'h60, 8'h40);
    waitHi(0, 20);
    rd(8'h60, 1'h0, 8'hc0);
    ev(6'h10);
    rd(8'h60, 1'h0, 8'h40);
    waitHi(0, 20);
    wr(8'h60, 8'hc0);
    rd(8'h60, 1'h0, 8'h40);
    ev(6'h02);
    cyc(20);
    `CHK("irqReq", 1'h0, irqReq)
    rd(8'h60, 1'h0, 8'hc0);
    doReset(1'h1);
    ev(6'h04);
    wr(8'h60, 8'h48);
    waitHi(0, 20);
    `CHK("resets", 0, nRst)
    ev(6'h30);
    rd(8'h60, 1'h0, 8'h08);
    waitHi(1, 12);
    ev(6'h08);
    wr(8'h60, 8'h48);
    waitHi(0, 20);
    waitHi(1, 10);
    doReset(1'h1);
    wr(8'h60, 8'h08);
    wr(8'h60, 8'h00);
    rd(8'h60, 1'h0, 8'h08);
    wr(8'h60, 8'h18);
    rd(8'h60, 1'h0, 8'h18);
    cyc(2);
    wr(8'h60, 8'h00);
    rd(8'h60, 1'h0, 8'h08);
    // kicks closer than the period keep reset away
    ev(6'h01);
    cyc(2);
    m = nRst;
    repeat (8) begin
      ev(6'h01);
      cyc(3);
    end
    // a frozen block must not count towards a time-out
    ev(6'h01);
    clkEn <= 1'h0;
    cyc(40);
    clkEn <= 1'h1;
    `CHK("resets", m, nRst)
    wr(8'h60, 8'h18, 1'h0, 1);
    wr(8'h60, 8'h09);
    rd(8'h60, 1'h0, 8'h19);
    waitHi(1, 40);
    cyc();
    waitHi(1, 40);
    `CHK("period", 15, k)
    wr(8'h60, 8'h18, 1'h0, 1);
    wr(8'h60, 8'h00);
    m = nRst;
    cyc(40);
    `CHK("resets", m, nRst)
    doReset(1'h0);
    waitHi(1, 20);
    summarize();
  end
endmodule // wdm_watchdog_ctrl_tb_top
